// file: gpio_pkg.sv
// Constants shared by the parallel port block and its port slice.
`default_nettype none
package gpio_pkg;
    // Register indices; byte address is four times the index.
    localparam logic [3:0] IDX_PORT_A = 4'h0;
    localparam logic [3:0] IDX_PORT_B = 4'h1;
    localparam logic [3:0] IDX_PORT_C = 4'h2;
    localparam logic [3:0] IDX_PORT_D = 4'h3;
    localparam logic [3:0] IDX_DIR_A  = 4'h4;
    localparam logic [3:0] IDX_DIR_B  = 4'h5;
    localparam logic [3:0] IDX_DIR_C  = 4'h6;
    localparam logic [3:0] IDX_CTRL   = 4'h7;
    localparam logic [3:0] IDX_CONV   = 4'h9;
    // Address slicing of the word index.
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 5;
    // Widths and bit positions.
    localparam int PORT_W      = 8;
    localparam int CLKOUT_BIT  = 3;
    localparam int CONV_ON_BIT = 5;
    localparam int PC2_BIT     = 2;
    // Reset values and other zero constants.
    localparam logic [7:0]  DIR_RESET   = 8'h00;
    localparam logic [7:0]  RDATA_RESET = 8'h00;
    localparam logic [7:0]  BYTE_ZERO   = 8'h00;
    localparam logic [23:0] RDATA_PAD   = 24'h000000;
    localparam logic [25:0] ADDR_HI_ZERO = 26'h0000000;
    // AHB-Lite encodings.
    localparam int         HTRANS_ACTIVE_BIT = 1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic       HRESP_OKAY = 1'b0;
endpackage : gpio_pkg
`default_nettype wire

// file: gpio_port_bits.sv
// One 8-bit bidirectional port: data latch, direction, pin sampling.
`timescale 1ns/1ps
`default_nettype none
module gpio_port_bits (
    // Clock and reset.
    input  wire logic                      clk,
    input  wire logic                      reset,
    // Pin side.
    input  wire logic [gpio_pkg::PORT_W-1:0] pin_in,
    output logic      [gpio_pkg::PORT_W-1:0] pin_out,
    output logic      [gpio_pkg::PORT_W-1:0] pin_oe,
    // Register side.
    input  wire logic [gpio_pkg::PORT_W-1:0] force_dir,
    input  wire logic                      write_latch,
    input  wire logic                      write_dir,
    input  wire logic [gpio_pkg::PORT_W-1:0] wdata,
    output logic      [gpio_pkg::PORT_W-1:0] dir_value,
    output logic      [gpio_pkg::PORT_W-1:0] read_value
);
    import gpio_pkg::*;

    typedef struct packed {
        logic [PORT_W-1:0] latch;
        logic [PORT_W-1:0] dir;
        logic [PORT_W-1:0] sync1;
        logic [PORT_W-1:0] sync2;
    } port_state_s;

    port_state_s state_reg;
    port_state_s state_next;
    logic [PORT_W-1:0] eff_dir;

    // Per bit, an output reads its latch and an input reads its pin.
    function automatic logic [PORT_W-1:0] pick_read(
        input logic [PORT_W-1:0] sel,
        input logic [PORT_W-1:0] latch,
        input logic [PORT_W-1:0] pin);
        pick_read = (sel & latch) | (~sel & pin);
    endfunction : pick_read

    ////////////////////////////////////////////////////////////////////
    // Next state. The latch is deliberately not reset, so software can
    // preload it across a reset before it turns pins into outputs.
    always_comb begin
        state_next       = state_reg;
        state_next.sync1 = pin_in;
        state_next.sync2 = state_reg.sync1;
        if (write_latch) begin
            state_next.latch = wdata; // RL6 RL7
        end
        if (write_dir) begin
            state_next.dir = wdata; // RL5
        end
        if (reset) begin
            state_next.dir = DIR_RESET; // RL3 RL4
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        state_reg <= state_next;
    end

    ////////////////////////////////////////////////////////////////////
    // Pin drive and processor read path.
    assign eff_dir    = state_reg.dir | force_dir;
    assign pin_oe     = eff_dir; // RL2
    assign pin_out    = state_reg.latch;
    assign dir_value  = state_reg.dir;
    assign read_value = pick_read(eff_dir, state_reg.latch,
                                  state_reg.sync2); // RL8 RL9

    ////////////////////////////////////////////////////////////////////
    // Checks.
    property p_dir_cleared;
        @(posedge clk) reset |=> (dir_value == DIR_RESET);
    endproperty
    a_dir_cleared: assert property (p_dir_cleared) // RL3
        else $error("direction not cleared by reset");

    // The latch may still be unknown before its first write, so the
    // comparison is exact rather than logical.
    property p_latch_kept;
        @(posedge clk) (reset && !write_latch) |=>
            (pin_out === $past(pin_out));
    endproperty
    a_latch_kept: assert property (p_latch_kept) // RL4
        else $error("reset disturbed the data latch");

    property p_dir_drives;
        @(posedge clk) disable iff (reset)
        write_dir |=> ((pin_oe & ~force_dir) ==
                       ($past(wdata) & ~force_dir));
    endproperty
    a_dir_drives: assert property (p_dir_drives) // RL2
        else $error("pin enable does not follow direction write");

    property p_write_input;
        @(posedge clk) disable iff (reset)
        (write_latch && !write_dir) |=>
            (((pin_oe & ~force_dir) == ($past(dir_value) & ~force_dir)) &&
             pin_out == $past(wdata));
    endproperty
    a_write_input: assert property (p_write_input) // RL6
        else $error("latch write changed direction");

    property p_write_output;
        @(posedge clk) disable iff (reset)
        write_latch |=> (pin_out == $past(wdata));
    endproperty
    a_write_output: assert property (p_write_output) // RL7
        else $error("latch write not driven to pin");

    property p_read_input;
        @(posedge clk) disable iff (reset)
        1'b1 ##2 1'b1 |-> ((read_value & ~pin_oe) ==
                           ($past(pin_in, 2) & ~pin_oe));
    endproperty
    a_read_input: assert property (p_read_input) // RL8
        else $error("input bit does not read the pin");

    property p_read_output;
        @(posedge clk) disable iff (reset)
        (read_value & pin_oe) === (pin_out & pin_oe);
    endproperty
    a_read_output: assert property (p_read_output) // RL9
        else $error("output bit does not read the latch");
endmodule : gpio_port_bits
`default_nettype wire

// file: gpio_ports.sv
// Parallel I/O ports A, B, C and input-only port D on AHB-Lite.
//
// Behaviour
// RL1 - Three 8-bit bidirectional ports plus one 8-bit input-only port.
// RL2 - A pin drives when its direction bit is one, else it is input.
// RL3 - Reset clears every direction register, so all pins start as inputs.
// RL4 - Reset leaves the output data latches untouched.
// RL5 - Direction registers are writable and read back the last value.
// RL6 - Data write on an input bit only loads the latch.
// RL7 - Data write on an output bit loads the latch and drives the pin.
// RL8 - Reading an input bit returns the sampled pin level.
// RL9 - Reading an output bit returns the latch, not the pin.
// RL10 - Clock-out enable puts the bus clock on port C pin two.
// RL11 - Clock-out affects only port C pin two.
// RL12 - Clock-out enable is bit 3 of control; bits 7 to 4 read zero.
// RL13 - Reset clears clock-out enable; low-power states keep it.
// RL14 - The input-only port has no direction and always reads its pins.
// RL15 - With the converter on, the shared pins feed the analog inputs.
// RL16 - Reset turns the converter off, making the shared port digital.
// RL17 - Software loads the latch before setting direction bits.
// RL18 - Software avoids reading the shared port during a conversion.
// RL19 - Converter-on is bit 5 of the converter register, selecting use.
// RL20 - The pin-two clock follows the bus clock without runt pulses.
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module gpio_ports (
    // Clock and reset.
    input  wire logic                        clk,
    input  wire logic                        reset,
    // AHB-Lite slave.
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic                        hready,
    input  wire logic [31:0]                 hwdata,
    output logic      [31:0]                 hrdata,
    output logic                             hreadyout,
    output logic                             hresp,
    // Port A pins.
    input  wire logic [gpio_pkg::PORT_W-1:0] port_a_in,
    output logic      [gpio_pkg::PORT_W-1:0] port_a_out,
    output logic      [gpio_pkg::PORT_W-1:0] port_a_oe,
    // Port B pins.
    input  wire logic [gpio_pkg::PORT_W-1:0] port_b_in,
    output logic      [gpio_pkg::PORT_W-1:0] port_b_out,
    output logic      [gpio_pkg::PORT_W-1:0] port_b_oe,
    // Port C pins.
    input  wire logic [gpio_pkg::PORT_W-1:0] port_c_in,
    output logic      [gpio_pkg::PORT_W-1:0] port_c_out,
    output logic      [gpio_pkg::PORT_W-1:0] port_c_oe,
    // Shared input-only pins and converter steering.
    input  wire logic [gpio_pkg::PORT_W-1:0] shared_input_pins,
    output logic                             converter_analog_select,
    output logic                             shared_digital_enable
);
    import gpio_pkg::*;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WAIT = 3'b010,
        BUS_DONE = 3'b100
    } bus_state_e;

    typedef struct packed {
        bus_state_e        bus;
        logic              pend_write;
        logic              pend_ok;
        logic [3:0]        pend_idx;
        logic [PORT_W-1:0] rdata;
        logic              clock_out_enable;
        logic              converter_on;
        logic              clk_out_active;
        logic              internal_bus_clock;
        logic [PORT_W-1:0] d_sync1;
        logic [PORT_W-1:0] d_sync2;
    } top_state_s;

    top_state_s        state_reg;
    top_state_s        state_next;
    logic              take;
    logic              access;
    logic [PORT_W-1:0] wbyte;
    logic [PORT_W-1:0] pc2_mask;
    logic [PORT_W-1:0] c_latch;
    logic [PORT_W-1:0] rd_a;
    logic [PORT_W-1:0] rd_b;
    logic [PORT_W-1:0] rd_c;
    logic [PORT_W-1:0] dir_a;
    logic [PORT_W-1:0] dir_b;
    logic [PORT_W-1:0] dir_c;
    logic              wr_a_data;
    logic              wr_b_data;
    logic              wr_c_data;
    logic              wr_a_dir;
    logic              wr_b_dir;
    logic              wr_c_dir;

    // True when the pending access is a valid write to the given index.
    function automatic logic write_hit(input top_state_s s,
                                       input logic [3:0] idx);
        write_hit = s.bus == BUS_WAIT && s.pend_write && s.pend_ok &&
                    s.pend_idx == idx;
    endfunction : write_hit

    ////////////////////////////////////////////////////////////////////
    // Bus decode. Only word transfers at the low register indices are
    // mapped; anything else reads zero, ignores writes, answers OKAY.
    assign take   = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
    assign access = hsize == HSIZE_WORD &&
                    haddr[31:IDX_MSB+1] == ADDR_HI_ZERO &&
                    haddr[1:0] == 2'h0;
    assign wbyte  = hwdata[PORT_W-1:0];

    // Register write strobes into the three port slices.
    assign wr_a_data = write_hit(state_reg, IDX_PORT_A);
    assign wr_b_data = write_hit(state_reg, IDX_PORT_B);
    assign wr_c_data = write_hit(state_reg, IDX_PORT_C);
    assign wr_a_dir  = write_hit(state_reg, IDX_DIR_A);
    assign wr_b_dir  = write_hit(state_reg, IDX_DIR_B);
    assign wr_c_dir  = write_hit(state_reg, IDX_DIR_C);

    ////////////////////////////////////////////////////////////////////
    // Next state. One wait cycle lets a write land before any read that
    // follows it back to back, at the cost of one cycle per transfer.
    always_comb begin
        state_next = state_reg;
        // Internal bus clock: half the system clock, from a flop.
        state_next.internal_bus_clock = ~state_reg.internal_bus_clock;
        // Switch the pin only as the bus clock falls: no runt pulses.
        if (state_reg.internal_bus_clock) begin
            state_next.clk_out_active = state_reg.clock_out_enable; // RL20
        end
        // Shared input pins pass two flops before anything reads them.
        state_next.d_sync1 = shared_input_pins;
        state_next.d_sync2 = state_reg.d_sync1;
        case (state_reg.bus)
            BUS_IDLE, BUS_DONE: begin
                if (take) begin
                    state_next.bus        = BUS_WAIT;
                    state_next.pend_write = hwrite;
                    state_next.pend_ok    = access;
                    state_next.pend_idx   = haddr[IDX_MSB:IDX_LSB];
                end else begin
                    state_next.bus = BUS_IDLE;
                end
            end
            BUS_WAIT: begin
                state_next.bus   = BUS_DONE;
                state_next.rdata = RDATA_RESET;
                if (state_reg.pend_ok && state_reg.pend_write) begin
                    if (state_reg.pend_idx == IDX_CTRL) begin
                        state_next.clock_out_enable =
                            wbyte[CLKOUT_BIT]; // RL10 RL12
                    end
                    if (state_reg.pend_idx == IDX_CONV) begin
                        state_next.converter_on =
                            wbyte[CONV_ON_BIT]; // RL19
                    end
                end else if (state_reg.pend_ok) begin
                    case (state_reg.pend_idx)
                        IDX_PORT_A: state_next.rdata = rd_a;
                        IDX_PORT_B: state_next.rdata = rd_b;
                        IDX_PORT_C: state_next.rdata = rd_c; // RL10
                        IDX_PORT_D: begin
                            state_next.rdata = state_reg.d_sync2; // RL14
                        end
                        IDX_DIR_A:  state_next.rdata = dir_a; // RL5
                        IDX_DIR_B:  state_next.rdata = dir_b;
                        IDX_DIR_C:  state_next.rdata = dir_c;
                        IDX_CTRL: begin
                            state_next.rdata[CLKOUT_BIT] =
                                state_reg.clock_out_enable; // RL12
                        end
                        IDX_CONV: begin
                            state_next.rdata[CONV_ON_BIT] =
                                state_reg.converter_on;
                        end
                        default: state_next.rdata = RDATA_RESET;
                    endcase
                end
            end
            default: state_next.bus = BUS_IDLE;
        endcase
        // Reset: control bits cleared, data latches left alone.
        if (reset) begin
            state_next.bus                = BUS_IDLE;
            state_next.pend_write         = 1'b0;
            state_next.pend_ok            = 1'b0;
            state_next.pend_idx           = IDX_PORT_A;
            state_next.rdata              = RDATA_RESET;
            state_next.clock_out_enable   = 1'b0; // RL13
            state_next.converter_on       = 1'b0; // RL16
            state_next.clk_out_active     = 1'b0;
            state_next.internal_bus_clock = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        state_reg <= state_next;
    end

    ////////////////////////////////////////////////////////////////////
    // Bus outputs.
    assign hreadyout = state_reg.bus != BUS_WAIT;
    assign hresp     = HRESP_OKAY;
    assign hrdata    = {RDATA_PAD, state_reg.rdata};

    ////////////////////////////////////////////////////////////////////
    // The three bidirectional ports. Only port C sees a forced bit.
    assign pc2_mask = PORT_W'(state_reg.clk_out_active) << PC2_BIT; // RL11

    gpio_port_bits u_port_a (
        .clk         (clk),
        .reset       (reset),
        .pin_in      (port_a_in),
        .pin_out     (port_a_out),
        .pin_oe      (port_a_oe),
        .force_dir   (BYTE_ZERO),
        .write_latch (wr_a_data),
        .write_dir   (wr_a_dir),
        .wdata       (wbyte),
        .dir_value   (dir_a),
        .read_value  (rd_a)
    ); // RL1

    gpio_port_bits u_port_b (
        .clk         (clk),
        .reset       (reset),
        .pin_in      (port_b_in),
        .pin_out     (port_b_out),
        .pin_oe      (port_b_oe),
        .force_dir   (BYTE_ZERO),
        .write_latch (wr_b_data),
        .write_dir   (wr_b_dir),
        .wdata       (wbyte),
        .dir_value   (dir_b),
        .read_value  (rd_b)
    );

    gpio_port_bits u_port_c (
        .clk         (clk),
        .reset       (reset),
        .pin_in      (port_c_in),
        .pin_out     (c_latch),
        .pin_oe      (port_c_oe),
        .force_dir   (pc2_mask),
        .write_latch (wr_c_data),
        .write_dir   (wr_c_dir),
        .wdata       (wbyte),
        .dir_value   (dir_c),
        .read_value  (rd_c)
    );

    // Pin two carries the bus clock while clock-out is active.
    assign port_c_out = (c_latch & ~pc2_mask) |
        (pc2_mask & {PORT_W{state_reg.internal_bus_clock}}); // RL10

    ////////////////////////////////////////////////////////////////////
    // Converter steering of the shared pins. The digital read path stays
    // usable either way; reading during a conversion only costs accuracy.
    assign converter_analog_select = state_reg.converter_on; // RL15
    assign shared_digital_enable   = ~state_reg.converter_on; // RL16

    ////////////////////////////////////////////////////////////////////
    // Checks.
    property p_clkout_reset;
        @(posedge clk) reset |=> (!state_reg.clock_out_enable &&
                                  !state_reg.clk_out_active);
    endproperty
    a_clkout_reset: assert property (p_clkout_reset) // RL13
        else $error("reset did not clear clock-out");

    property p_conv_reset;
        @(posedge clk) reset |=> (!converter_analog_select &&
                                  shared_digital_enable);
    endproperty
    a_conv_reset: assert property (p_conv_reset) // RL16
        else $error("reset did not turn converter off");

    property p_ctrl_read;
        @(posedge clk) disable iff (reset)
        (state_reg.bus == BUS_WAIT && !state_reg.pend_write &&
         state_reg.pend_ok && state_reg.pend_idx == IDX_CTRL) |=>
            (hrdata[31:CLKOUT_BIT+1] == 28'h0000000 &&
             hrdata[CLKOUT_BIT] == $past(state_reg.clock_out_enable));
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) // RL12
        else $error("control read value wrong");

    property p_clkout_on;
        @(posedge clk) disable iff (reset)
        state_reg.clock_out_enable [*3] |->
            (port_c_oe[PC2_BIT] &&
             port_c_out[PC2_BIT] == state_reg.internal_bus_clock);
    endproperty
    a_clkout_on: assert property (p_clkout_on) // RL10
        else $error("pin two does not carry the bus clock");

    property p_clkout_only_pc2;
        @(posedge clk) disable iff (reset)
        ((port_c_oe & ~pc2_mask) == (dir_c & ~pc2_mask)) &&
        ((port_c_out & ~pc2_mask) === (c_latch & ~pc2_mask));
    endproperty
    a_clkout_only_pc2: assert property (p_clkout_only_pc2) // RL11
        else $error("clock-out disturbed other port C pins");

    property p_clkout_switch;
        @(posedge clk) disable iff (reset)
        $changed(state_reg.clk_out_active) |->
            !state_reg.internal_bus_clock;
    endproperty
    a_clkout_switch: assert property (p_clkout_switch) // RL20
        else $error("clock-out switched mid phase");

    property p_bus_clock_runs;
        @(posedge clk) disable iff (reset)
        !reset |=> (state_reg.internal_bus_clock !=
                    $past(state_reg.internal_bus_clock));
    endproperty
    a_bus_clock_runs: assert property (p_bus_clock_runs) // RL20
        else $error("bus clock stalled");

    property p_conv_write;
        @(posedge clk) disable iff (reset)
        write_hit(state_reg, IDX_CONV) |=>
            (converter_analog_select == $past(wbyte[CONV_ON_BIT]));
    endproperty
    a_conv_write: assert property (p_conv_write) // RL15
        else $error("converter select not updated");

    property p_dir_readback;
        @(posedge clk) disable iff (reset)
        wr_a_dir |=> (dir_a == $past(wbyte));
    endproperty
    a_dir_readback: assert property (p_dir_readback) // RL5
        else $error("direction register lost write");

    property p_port_d_read;
        @(posedge clk) disable iff (reset)
        (state_reg.bus == BUS_WAIT && !state_reg.pend_write &&
         state_reg.pend_ok && state_reg.pend_idx == IDX_PORT_D) |=>
            (hrdata[PORT_W-1:0] == $past(shared_input_pins, 3));
    endproperty
    a_port_d_read: assert property (p_port_d_read) // RL14
        else $error("shared port read wrong");
endmodule : gpio_ports
`default_nettype wire

// file: pin_board.sv
// Board model that resolves each pin of ports A, B and C from the block and the board.
`timescale 1ns/1ps
`default_nettype none
module pin_board (
    // Block side.
    input  wire logic [23:0] pin_out,
    input  wire logic [23:0] pin_oe,
    // Board drive.
    input  wire logic [23:0] ext,
    // Levels seen at the block inputs.
    output logic      [23:0] pin_lvl
);
    // A driven pin shows the block's value, so the board never fights it.
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule : pin_board
`default_nettype wire

// file: test_gpio_ports.sv
// Self-checking bench for the parallel port block.
`timescale 1ns/1ps
`default_nettype none
module test_gpio_ports;
    import gpio_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        rd = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] seed = 32'h00008AF3;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, conv_sel, dig_en;
    logic [7:0]  a_out, a_oe, b_out, b_oe, c_out, c_oe, lat, msk, pin;
    logic [7:0]  d_pins = 8'h00;
    logic [23:0] ext = 24'h0;
    logic [23:0] lvl, oe_all, out_all;
    logic [31:0] exp_q[$];
    int          fail_count = 0;
    int          num_checks = 0;

    assign oe_all  = {c_oe, b_oe, a_oe};
    assign out_all = {c_out, b_out, a_out};
    gpio_ports i_gpio_ports (.clk(clk), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .port_a_in(lvl[7:0]),
        .port_a_out(a_out), .port_a_oe(a_oe), .port_b_in(lvl[15:8]),
        .port_b_out(b_out), .port_b_oe(b_oe), .port_c_in(lvl[23:16]),
        .port_c_out(c_out), .port_c_oe(c_oe), .shared_input_pins(d_pins),
        .converter_analog_select(conv_sel), .shared_digital_enable(dig_en));
    pin_board i_pin_board (.pin_out(out_all), .pin_oe(oe_all), .ext(ext),
        .pin_lvl(lvl));

    ////////////////////////////////////////////////////////////////////////
    // Clock, comparison and bus helpers.
    initial forever #2.5 clk = ~clk;
    task chk(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask : chk
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    // Hold each phase until hready is seen high, as the bus demands.
    task xfer(input logic w, input logic [3:0] idx, input logic [7:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {26'h0, idx, 2'h0};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        rd <= !w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd <= 1'b0;
    endtask : xfer
    task wr(input logic [3:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
    endtask : wr
    task rdx(input logic [3:0] idx, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        xfer(1'b0, idx, 8'h00);
    endtask : rdx
    // Read data is taken at the edge that ends the data phase.
    always @(posedge clk) begin
        if (rd && hreadyout) begin
            chk(hrdata, exp_q.pop_front());
            chk({31'h0, hresp}, 32'h0);
        end
    end
    task give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        for (int i = 4; i < 8; i++) rdx(i[3:0], 8'h00);
        chk({6'h0, conv_sel, dig_en, oe_all}, 32'h01000000);
        for (int p = 0; p < 3; p++) begin
            ext <= {rnd(), rnd(), rnd()};
            lat = rnd();
            msk = rnd();
            wr(p[3:0], lat);
            chk({24'h0, oe_all[p*8+:8]}, 32'h0);
            rdx(p[3:0], ext[p*8+:8]);
            wr(4'(4 + p), msk);
            rdx(4'(4 + p), msk);
            #1 chk({24'h0, oe_all[p*8+:8]}, {24'h0, msk});
            chk({24'h0, out_all[p*8+:8] & msk}, {24'h0, lat & msk});
            rdx(p[3:0], (lat & msk) | (ext[p*8+:8] & ~msk));
        end
        // Clock-out on port C pin two only; other C pins stay inputs.
        wr(IDX_DIR_C, 8'h00);
        wr(IDX_CTRL, 8'hFF);
        rdx(IDX_CTRL, 8'h08);
        #1 chk({24'h0, c_oe}, 32'h04);
        pin = c_out;
        @(posedge clk);
        #1 chk({31'h0, pin[2] ^ c_out[2]}, 32'h1);
        rdx(IDX_PORT_C, (lat & 8'h04) | (ext[23:16] & 8'hFB));
        wr(IDX_CTRL, 8'h00);
        repeat (3) @(posedge clk);
        #1 chk({24'h0, c_oe}, 32'h0);
        // Input-only port, converter steering and an unmapped word.
        pin = rnd();
        @(posedge clk);
        d_pins <= pin;
        wr(IDX_PORT_D, ~pin);
        rdx(IDX_PORT_D, pin);
        wr(IDX_CONV, 8'hFF);
        rdx(IDX_CONV, 8'h20);
        chk({30'h0, conv_sel, dig_en}, 32'h2);
        wr(IDX_CONV, 8'h00);
        chk({30'h0, conv_sel, dig_en}, 32'h1);
        rdx(IDX_PORT_D, pin);
        wr(4'h8, 8'hFF);
        rdx(4'h8, 8'h00);
        // A second reset clears controls but keeps the data latch.
        wr(IDX_PORT_A, 8'h5A);
        wr(IDX_CTRL, 8'h08);
        wr(IDX_CONV, 8'h20);
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rdx(IDX_DIR_A, 8'h00);
        rdx(IDX_CTRL, 8'h00);
        chk({31'h0, conv_sel}, 32'h0);
        wr(IDX_DIR_A, 8'hFF);
        rdx(IDX_PORT_A, 8'h5A);
        repeat (2) @(posedge clk);
        give_verdict();
    end
endmodule : test_gpio_ports
`default_nettype wire
